// *** core/spts_map.svh ***
// Purpose: constants of the serial power table and status block
// Assumes: included by bare name
// Notes: definitions only
`ifndef SPTS_MAP_SVH
`define SPTS_MAP_SVH
// header address of the power amplifier table
`define SPTS_ADDR_PWR_TABLE 6'h3E
`define SPTS_TABLE_DEPTH 8
`define SPTS_TABLE_RESET 8'h00
`define SPTS_IDX_RESET 3'h0
`define SPTS_IDX_LAST 3'h7
// main state codes of status bits 6:4
`define SPTS_ST_IDLE 3'h0
`define SPTS_ST_TX 3'h2
`define SPTS_ST_FAST_TX 3'h3
`define SPTS_ST_CALIB 3'h4
`define SPTS_ST_SETTLE 3'h5
`define SPTS_ST_UNDERFLOW 3'h7
// free byte count saturates here
`define SPTS_FREE_MAX 4'hF
`define SPTS_FREE_MAX_W 7'h0F
`define SPTS_BIT_LAST 3'h7
`endif

// *** core/spts_pkg.sv ***
// Purpose: types of the serial power table and status block
// Assumes: constants live in spts_map.svh
// Notes: no timing here
package spts_pkg;
  typedef struct packed {
    logic rw;
    logic burst;
    logic [5:0] addr;
  } spts_hdr_t;
  typedef struct packed {
    logic not_ready;
    logic [2:0] state;
    logic [3:0] free;
  } spts_status_t;
  typedef enum logic {SPTS_PH_HDR, SPTS_PH_DATA} spts_phase_t;
endpackage

// *** core/spts_top.sv ***
// Purpose: serial slave with power amplifier table, status byte, status pins
// Assumes: host is serial master, clock idles low, data sampled on rising edge
// Notes: link pins are sampled by sys_clk, so serial clock must stay slow
// Functional notes
// RL1: address 0x3E selects the amplifier table
// RL2: eight byte table, power index selects entry
// RL3: index steps per byte, zero while deselected
// RL4: burst index wraps from seven to zero
// RL5: burst bit and read bit pick access
// RL6: host deselects before reading back single byte
// RL7: entering sleep clears the table
// RL8: status bit 7 is active-low not ready
// RL9: host transfers only when ready reads low
// RL10: status bits 6:4 report the main state
// RL11: idle code may stand for transitional states
// RL12: underflow code reported, host flushes to clear
// RL13: status bits 3:0 free count, saturates 15
// RL14: dedicated and shared status pins, shared tristate default
// RL15: shared pin is serial output while selected
// RL16: dedicated pin becomes input in serial transmit
// RL17: host sets test register for idle sensor
// RL18: header holds read bit, burst bit, address
// RL19: status byte shifted out during the header
// RL20: all bits travel most significant first
// RL21: deselect mid transfer abandons the transfer
// RL22: write hits current entry, read returns it next
`timescale 1ns/10ps
`default_nettype none
`include "spts_map.svh"
module spts_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  output logic spi_so_o,
  output logic spi_so_oe,
  input wire logic ded_pin_i,
  output logic ded_pin_o,
  output logic ded_pin_oe,
  input wire logic chip_ready,
  input wire logic [2:0] main_state,
  input wire logic tx_underflow,
  input wire logic [6:0] tx_free_count,
  input wire logic sleep_entry,
  input wire logic [2:0] power_index,
  input wire logic shared_pin_enable,
  input wire logic shared_status_sig,
  input wire logic ded_status_sig,
  input wire logic serial_tx_mode,
  output logic [7:0] pa_setting,
  output logic serial_tx_data
);
  // two-stage synchronisers; sclk gets a third stage for edges
  logic cs_s1, cs_s2;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic si_s1, si_s2;
  logic ded_s1, ded_s2;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
      ded_s1 <= 1'b0;
      ded_s2 <= 1'b0;
    end else begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      si_s1 <= spi_si;
      si_s2 <= si_s1;
      ded_s1 <= ded_pin_i;
      ded_s2 <= ded_s1;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;

  // status byte, built live from the device state
  spts_pkg::spts_status_t status_now;
  always_comb begin
    status_now.not_ready = ~chip_ready; // [RL8]
    // idle reported as given, transitional states may show as idle [RL11]
    status_now.state = tx_underflow ? `SPTS_ST_UNDERFLOW : main_state; // [RL10] [RL12]
    status_now.free = (tx_free_count >= `SPTS_FREE_MAX_W) ? `SPTS_FREE_MAX
                      : tx_free_count[3:0]; // [RL13]
  end

  // transfer state
  spts_pkg::spts_phase_t phase_reg, phase_next;
  spts_pkg::spts_hdr_t hdr_reg, hdr_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [6:0] rx_sh_reg, rx_sh_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic so_bit_reg, so_bit_next;
  logic started_reg, started_next;
  logic [2:0] idx_reg, idx_next;
  logic [7:0] tab_reg [`SPTS_TABLE_DEPTH];
  logic [7:0] tab_next [`SPTS_TABLE_DEPTH];

  logic [7:0] rx_byte;
  logic byte_done;
  logic tab_hit;
  logic [2:0] idx_inc;
  spts_pkg::spts_hdr_t hdr_now;
  assign rx_byte = {rx_sh_reg, si_s2}; // [RL20]
  assign byte_done = sclk_rise & ~cs_s2 & (bit_cnt_reg == `SPTS_BIT_LAST);
  assign hdr_now = spts_pkg::spts_hdr_t'(rx_byte); // [RL18]
  assign tab_hit = (hdr_reg.addr == `SPTS_ADDR_PWR_TABLE); // [RL1]
  assign idx_inc = idx_reg + 3'h1; // natural 3-bit wrap [RL4]

  always_comb begin
    phase_next = phase_reg;
    hdr_next = hdr_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_sh_next = rx_sh_reg;
    tx_sh_next = tx_sh_reg;
    so_bit_next = so_bit_reg;
    started_next = started_reg;
    idx_next = idx_reg;
    tab_next = tab_reg;
    if (cs_s2) begin
      // deselect drops any partial byte and rewinds the index [RL21] [RL3]
      phase_next = spts_pkg::SPTS_PH_HDR;
      bit_cnt_next = 3'h0;
      started_next = 1'b0;
      idx_next = `SPTS_IDX_RESET;
      so_bit_next = 1'b1;
    end else begin
      if (sclk_rise) begin
        rx_sh_next = rx_byte[6:0];
        bit_cnt_next = bit_cnt_reg + 3'h1;
        started_next = 1'b1;
      end
      if (!started_reg) begin
        // keep status fresh so not-ready falls as soon as it can [RL19] [RL8]
        so_bit_next = status_now[7];
        tx_sh_next = {status_now[6:0], 1'b0};
      end else if (sclk_fall) begin
        so_bit_next = tx_sh_reg[7]; // [RL20]
        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
      end
      if (byte_done) begin
        if (phase_reg == spts_pkg::SPTS_PH_HDR) begin
          hdr_next = hdr_now;
          phase_next = spts_pkg::SPTS_PH_DATA;
          // read returns the current entry in the next slot [RL22] [RL5]
          if (hdr_now.addr == `SPTS_ADDR_PWR_TABLE && hdr_now.rw) begin
            tx_sh_next = tab_reg[idx_reg];
          end else begin
            tx_sh_next = status_now;
          end
        end else begin
          if (tab_hit) begin
            if (!hdr_reg.rw) begin
              tab_next[idx_reg] = rx_byte; // [RL22]
            end
            idx_next = idx_inc; // [RL3] [RL4]
          end
          if (hdr_reg.burst) begin
            // burst keeps going until deselect [RL5]
            tx_sh_next = (tab_hit && hdr_reg.rw) ? tab_reg[idx_inc] : status_now;
          end else begin
            phase_next = spts_pkg::SPTS_PH_HDR;
            tx_sh_next = status_now; // [RL19]
          end
        end
      end
    end
    if (sleep_entry) begin
      for (int i = 0; i < `SPTS_TABLE_DEPTH; i++) begin
        tab_next[i] = `SPTS_TABLE_RESET; // [RL7]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= spts_pkg::SPTS_PH_HDR;
      hdr_reg <= '0;
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
      tx_sh_reg <= 8'h00;
      so_bit_reg <= 1'b1;
      started_reg <= 1'b0;
      idx_reg <= `SPTS_IDX_RESET;
      for (int i = 0; i < `SPTS_TABLE_DEPTH; i++) begin
        tab_reg[i] <= `SPTS_TABLE_RESET;
      end
    end else begin
      phase_reg <= phase_next;
      hdr_reg <= hdr_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      so_bit_reg <= so_bit_next;
      started_reg <= started_next;
      idx_reg <= idx_next;
      tab_reg <= tab_next;
    end
  end

  // pins; every output is registered
  logic so_o_next, so_oe_next, ded_o_next, ded_oe_next;
  logic [7:0] pa_next;
  logic tx_data_next;
  always_comb begin
    pa_next = tab_reg[power_index]; // [RL2]
    if (!cs_s2) begin
      so_o_next = so_bit_reg; // [RL15]
      so_oe_next = 1'b1;
    end else begin
      so_o_next = shared_status_sig; // [RL14]
      so_oe_next = shared_pin_enable;
    end
    if (serial_tx_mode) begin
      // host drives transmit data on the dedicated pin [RL16]
      ded_o_next = 1'b0;
      ded_oe_next = 1'b0;
      tx_data_next = ded_s2;
    end else begin
      ded_o_next = ded_status_sig; // [RL14]
      ded_oe_next = 1'b1;
      tx_data_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_so_o <= 1'b0;
      spi_so_oe <= 1'b0;
      ded_pin_o <= 1'b0;
      ded_pin_oe <= 1'b0;
      pa_setting <= `SPTS_TABLE_RESET;
      serial_tx_data <= 1'b0;
    end else begin
      spi_so_o <= so_o_next;
      spi_so_oe <= so_oe_next;
      ded_pin_o <= ded_o_next;
      ded_pin_oe <= ded_oe_next;
      pa_setting <= pa_next;
      serial_tx_data <= tx_data_next;
    end
  end

  // checks
  property p_idx_cs;
    @(posedge sys_clk) disable iff (!rst_n)
    cs_s2 |=> (idx_reg == `SPTS_IDX_RESET);
  endproperty
  a_idx_cs: assert property (p_idx_cs) else $error("index not zero while deselected"); // [RL3]

  property p_idx_step;
    @(posedge sys_clk) disable iff (!rst_n)
    (byte_done && phase_reg == spts_pkg::SPTS_PH_DATA && tab_hit)
      |=> (idx_reg == $past(idx_reg) + 3'h1) || $past(cs_s2);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index did not step"); // [RL3]

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (byte_done && phase_reg == spts_pkg::SPTS_PH_DATA && tab_hit
      && idx_reg == `SPTS_IDX_LAST) |=> (idx_reg == 3'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("index did not wrap"); // [RL4]

  property p_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (byte_done && phase_reg == spts_pkg::SPTS_PH_DATA && tab_hit
      && !hdr_reg.rw && !sleep_entry)
      |=> (tab_reg[$past(idx_reg)] == $past(rx_byte));
  endproperty
  a_write: assert property (p_write) else $error("table write lost"); // [RL22]

  property p_sleep;
    @(posedge sys_clk) disable iff (!rst_n)
    sleep_entry |=> (tab_reg[0] == 8'h00) && (tab_reg[7] == 8'h00)
      && (tab_reg[3] == 8'h00);
  endproperty
  a_sleep: assert property (p_sleep) else $error("table kept over sleep"); // [RL7]

  property p_so_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    !cs_s2 |=> spi_so_oe ##0 (spi_so_o == $past(so_bit_reg));
  endproperty
  a_so_sel: assert property (p_so_sel) else $error("shared pin not serial out"); // [RL15]

  property p_shared_z;
    @(posedge sys_clk) disable iff (!rst_n)
    (cs_s2 && !shared_pin_enable) |=> !spi_so_oe;
  endproperty
  a_shared_z: assert property (p_shared_z) else $error("shared pin driven by default"); // [RL14]

  property p_ded_in;
    @(posedge sys_clk) disable iff (!rst_n)
    serial_tx_mode |=> !ded_pin_oe && (serial_tx_data == $past(ded_s2));
  endproperty
  a_ded_in: assert property (p_ded_in) else $error("dedicated pin not an input"); // [RL16]

  property p_not_ready;
    @(posedge sys_clk) disable iff (!rst_n)
    (!cs_s2 && !started_reg && !chip_ready) |=> so_bit_reg;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("ready shown too early"); // [RL8]

  property p_underflow;
    @(posedge sys_clk) disable iff (!rst_n)
    (tx_underflow && !cs_s2 && !started_reg) |=> (tx_sh_reg[7:5] == `SPTS_ST_UNDERFLOW);
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow code missing"); // [RL12]

  property p_pa;
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> (pa_setting == $past(tab_reg[power_index]));
  endproperty
  a_pa: assert property (p_pa) else $error("amplifier setting wrong entry"); // [RL2]
endmodule
`default_nettype wire

// *** verif/spts_host.sv ***
// Purpose: host serial master model for the power table block
// Assumes: mode 0, serial clock idles low, 160 ns period
// Notes: released shared line shows the inverse of its last driven bit
`timescale 1ns/10ps
`default_nettype none
module spts_host (
  input wire logic sys_clk,
  input wire logic so_o,
  input wire logic so_oe,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  logic so_last = 1'b0;
  logic so_wire;
  // no pull on the line: released, it shows the inverse so a stale bit cannot match
  assign so_wire = so_oe ? so_o : ~so_last;
  always @(posedge sys_clk) begin
    if (so_oe) begin
      so_last <= so_o;
    end
  end
  initial begin
    cs_n <= 1'b1;
    sclk <= 1'b0;
    si <= 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // raising select restarts the index before a readback
  task automatic sel(input logic v);
    wait_clk(1);
    cs_n <= v;
    wait_clk(20);
  endtask
  // msb first, 80 ns high and low, so taken at each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nbits);
    for (int i = 7; i > 7 - nbits; i--) begin
      si <= tx[i];
      wait_clk(16);
      sclk <= 1'b1;
      rx[i] = so_wire;
      wait_clk(16);
      sclk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/test_spi_power_table_status.sv ***
// Purpose: self-checking bench of the power table and status block
// Assumes: host model drives the serial pins
// Notes: table entries and status codes worked out here
`timescale 1ns/10ps
`default_nettype none
module test_spi_power_table_status;
  logic sys_clk = 1'b0;
  logic rst_n, cs_n, sclk, si, so_o, so_oe, ded_i, ded_o, ded_oe, ded_drv;
  logic chip_ready, tx_underflow, sleep_entry, sh_en, sh_sig, ded_sig, tx_mode, tx_data;
  logic [2:0] main_state, power_index;
  logic [6:0] free_cnt;
  logic [7:0] pa_setting, st, rd;
  int bad_count = 0;
  int tests_run = 0;
  logic need_rdy = 1'b1;
  // write header of the test control register, address arbitrary here
  localparam logic [7:0] TEST_HDR = 8'h2A;
  logic [2:0] ms_v [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h2, 3'h0};
  logic [6:0] fc_v [6] = '{7'h00, 7'h0E, 7'h0F, 7'h40, 7'h05, 7'h01};
  logic [7:0] ex_v [6] = '{8'h20, 8'h3E, 8'h4F, 8'h5F, 8'h75, 8'h81};
  always #2.5 sys_clk = ~sys_clk;
  // dedicated pin level from both drivers
  assign ded_i = ded_oe ? ded_o : ded_drv;
  spts_top DUT (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .spi_cs_n(cs_n),
    .spi_sclk(sclk),
    .spi_si(si),
    .spi_so_o(so_o),
    .spi_so_oe(so_oe),
    .ded_pin_i(ded_i),
    .ded_pin_o(ded_o),
    .ded_pin_oe(ded_oe),
    .chip_ready(chip_ready),
    .main_state(main_state),
    .tx_underflow(tx_underflow),
    .tx_free_count(free_cnt),
    .sleep_entry(sleep_entry),
    .power_index(power_index),
    .shared_pin_enable(sh_en),
    .shared_status_sig(sh_sig),
    .ded_status_sig(ded_sig),
    .serial_tx_mode(tx_mode),
    .pa_setting(pa_setting),
    .serial_tx_data(tx_data)
  );
  spts_host HOST (
    .sys_clk(sys_clk),
    .so_o(so_o),
    .so_oe(so_oe),
    .cs_n(cs_n),
    .sclk(sclk),
    .si(si)
  );
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // header goes out once the line shows ready low, or at once when need_rdy is clear, or after 40 clocks
  task automatic start(input logic [7:0] hdr, output logic [7:0] s);
    int n = 0;
    HOST.sel(1'b0);
    while (need_rdy && !(so_oe === 1'b1 && so_o === 1'b0) && n < 40) begin
      HOST.wait_clk(1);
      n++;
    end
    if (n == 40) begin
      bad_count++;
      $display("BAD %0t ready never low", $time);
    end
    HOST.xfer(hdr, s, 8);
  endtask
  // ninth burst byte wraps onto entry 0
  function automatic logic [7:0] ent(input int k);
    return (k % 8 == 0) ? 8'h18 : 8'h10 + 8'(k);
  endfunction
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    {rst_n, ded_drv, tx_underflow, sleep_entry, sh_en, sh_sig, ded_sig, tx_mode} <= '0;
    chip_ready <= 1'b1;
    main_state <= 3'h0;
    power_index <= 3'h0;
    free_cnt <= 7'h14;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    HOST.wait_clk(3);
    start(8'h7E, st); check(st, 8'h0F);
    for (int k = 0; k < 9; k++) begin
      HOST.xfer(8'h10 + 8'(k), rd, 8); check(rd, 8'h0F);
    end
    HOST.sel(1'b1);
    start(8'hFE, st);
    for (int k = 0; k < 9; k++) begin
      HOST.xfer(8'h00, rd, 8); check(rd, ent(k));
    end
    HOST.sel(1'b1);
    for (int k = 0; k < 8; k++) begin
      power_index <= 3'(k);
      HOST.wait_clk(4); check(pa_setting, ent(k));
    end
    start(8'h3E, st);
    HOST.xfer(8'hA5, rd, 8);
    HOST.sel(1'b1);
    start(8'hBE, st);
    HOST.xfer(8'h00, rd, 8); check(rd, 8'hA5);
    HOST.sel(1'b1);
    // a cut byte and a foreign address must leave entry 0 alone
    start(8'h7E, st);
    HOST.xfer(8'h5A, rd, 4);
    HOST.sel(1'b1);
    start(8'h3F, st);
    HOST.xfer(8'h77, rd, 8);
    HOST.sel(1'b1);
    // sensor setting of the test register, then its default back; status comes out
    start(TEST_HDR, st);
    HOST.xfer(8'hBF, rd, 8); check(rd, 8'h0F);
    HOST.sel(1'b1);
    start(TEST_HDR, st);
    HOST.xfer(8'h7F, rd, 8); check(rd, 8'h0F);
    HOST.sel(1'b1);
    start(8'hBE, st);
    HOST.xfer(8'h00, rd, 8); check(rd, 8'hA5);
    HOST.sel(1'b1);
    for (int k = 0; k < 6; k++) begin
      chip_ready <= (k != 5);
      main_state <= ms_v[k];
      tx_underflow <= (k == 4);
      free_cnt <= fc_v[k];
      // the not-ready case reads the status on purpose without waiting
      need_rdy = (k != 5);
      start(8'h3D, st); check(st, ex_v[k]);
      HOST.sel(1'b1);
    end
    need_rdy = 1'b1;
    chip_ready <= 1'b1;
    sleep_entry <= 1'b1;
    HOST.wait_clk(1);
    sleep_entry <= 1'b0;
    HOST.wait_clk(4); check(pa_setting, 8'h00);
    // both levels of every pin input, shared pin released and driven
    for (int v = 0; v < 2; v++) begin
      sh_en <= v[0];
      sh_sig <= ~v[0];
      ded_sig <= v[0];
      tx_mode <= 1'b0;
      HOST.wait_clk(6); check({6'h00, so_oe, so_o}, {6'h00, v[0], ~v[0]});
      check({6'h00, ded_oe, ded_o}, {6'h00, 1'b1, v[0]});
      HOST.sel(1'b0); check({6'h00, so_oe, so_o}, 8'h02);
      HOST.sel(1'b1);
      tx_mode <= 1'b1;
      ded_drv <= ~v[0];
      HOST.wait_clk(8); check({6'h00, ded_oe, tx_data}, {6'h00, 1'b0, ~v[0]});
    end
    tx_mode <= 1'b0;
    HOST.wait_clk(6); check({6'h00, ded_oe, tx_data}, 8'h02);
    finish_test();
  end
endmodule
`default_nettype wire
